// [rtl/mab_pkg.sv]
// Overview of operation
// RQ1: address-disable strap low at reset locks status and user-zone pins normal.
// RQ2: nonmux address leads the mux address by half a clock-output period.
// RQ3: nonmux address outputs float during bus hold or reset.
// RQ4: first state drives low eight address bits on low mux lines.
// RQ5: write data driven on mux lines in states two, three and four.
// RQ6: read data captured from mux lines at end of third state.
// RQ7: show-read strap or show-read bit puts internal read data out, states 3-4.
// RQ8: wide variant uses 16-bit data; narrow variant uses address-only upper lines.
// RQ9: address phase on mux lines can be suppressed via strap at reset.
// RQ10: low-byte strobe negated floats low mux lines in states two to four.
// RQ11: mux lines float throughout bus hold or reset.
// RQ12: configuration straps on mux lines latched at reset release.
// RQ13: strap high plus disable-address bit: address only on nonmux outputs; the code applies this in sel_mem cycles only.
// RQ14: address-disable strap sampled within three crystal clocks; held till reset.
// RQ15: each bus cycle runs four states: address then three data states.
package mab_pkg;
    // ------------------------------------------------------------
    // widths and timing
    // ------------------------------------------------------------
    localparam int ADDR_W     = 20;
    localparam int DATA_W     = 16;
    localparam int BYTE_W     = 8;
    localparam int STRAP_LAT  = 3;     // crystal clocks after reset release
    localparam logic [1:0] STRAP_CNT_MAX = 2'h2;
    // half-period phase of the first clock output
    localparam logic CLK_PH_LO = 1'b0;
    localparam logic CLK_PH_HI = 1'b1;

    // bus states
    typedef enum logic [2:0] {
        MAB_IDLE = 3'b000,
        MAB_T1   = 3'b001,
        MAB_T2   = 3'b010,
        MAB_T3   = 3'b011,
        MAB_T4   = 3'b100
    } mab_state_t;

    // request from the core
    typedef struct packed {
        logic              write;
        logic              lo_en;     // low byte participates
        logic              hi_en;     // high byte participates
        logic              sel_mem;   // lower or upper memory select cycle
        logic              internal;  // internal memory read (show-read)
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mab_req_t;

    // pad group for the mux lines
    typedef struct packed {
        logic [DATA_W-1:0] o;
        logic [DATA_W-1:0] oe_n;
    } mab_pad_t;
endpackage

// [rtl/mab_bus.sv]
`timescale 1ns/1ps
`default_nettype none
module mab_bus #(
    parameter bit WIDE = 1'b1  // 1: 16-bit data, 0: 8-bit with address-only
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    // core request side
    input  wire logic                    req_valid,
    input  wire mab_pkg::mab_req_t       req,
    output logic                         req_ready,
    output logic                         rd_valid,
    output logic [mab_pkg::DATA_W-1:0]   rd_data,
    input  wire logic [mab_pkg::DATA_W-1:0] int_rd_data,
    // control inputs
    input  wire logic                    hold,
    input  wire logic                    show_read_bit,
    input  wire logic                    disable_address_bit,
    // strap pins
    input  wire logic                    show_read_strap,
    input  wire logic                    address_disable_strap,
    // pins
    output logic                         first_clock_output,
    output logic [mab_pkg::ADDR_W-1:0]   nonmux_address_outputs,
    output logic                         nonmux_oe_n,
    output logic [mab_pkg::DATA_W-1:0]   mux_o,
    output logic [mab_pkg::DATA_W-1:0]   mux_oe_n,
    input  wire logic [mab_pkg::DATA_W-1:0] mux_i,
    // configuration results
    output logic [mab_pkg::DATA_W-1:0]   reset_config,
    output logic                         pins_locked_normal,
    output logic                         addr_suppress_en,
    output logic                         show_read_en
);
    import mab_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mab_state_t        st;
        logic              ph;
        logic [1:0]        scnt;
        logic              sdone;
        logic              address_disable_strap_lo;
        logic              sren_lo;
        logic [DATA_W-1:0] cfg;
        mab_req_t          cur;
        logic              sup;      // address phase suppressed this cycle
        logic [ADDR_W-1:0] na;
        logic              na_oe_n;
        logic [DATA_W-1:0] mo;
        logic [DATA_W-1:0] moe_n;
        logic              rv;
        logic [DATA_W-1:0] rd;
    } mab_st_t;

    mab_st_t s_r, s_nxt;

    // two-flop synchronisers for pins
    logic [DATA_W-1:0] mux_m_r, mux_s_r;
    logic [1:0]        strap_m_r, strap_s_r;
    logic              hold_m_r, hold_s_r;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // mux lines keep sampling in reset so the straps reach the capture
    always_ff @(posedge clk) begin
        mux_m_r <= mux_i;
        mux_s_r <= mux_m_r;
    end

    // strap and hold pins, parked at their idle levels in reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_m_r <= 2'h3;
            strap_s_r <= 2'h3;
            hold_m_r  <= 1'b0;
            hold_s_r  <= 1'b0;
        end else begin
            strap_m_r <= {address_disable_strap, show_read_strap};
            strap_s_r <= strap_m_r;
            hold_m_r  <= hold;
            hold_s_r  <= hold_m_r;
        end
    end

    logic idle_pins;
    logic [DATA_W-1:0] lane_oe_n;
    logic [DATA_W-1:0] addr_lo;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rv = 1'b0;
        s_nxt.ph = ~s_r.ph;
        idle_pins = hold_s_r;
        lane_oe_n = '1;
        addr_lo = '0;
        // strap capture after reset release
        if (!s_r.sdone) begin
            if (s_r.scnt == 2'h0) begin
                s_nxt.cfg = mux_s_r;                       // see RQ12
            end
            if (s_r.scnt == STRAP_CNT_MAX) begin
                s_nxt.address_disable_strap_lo = ~strap_s_r[1];             // see RQ14
                s_nxt.sren_lo = ~strap_s_r[0];             // see RQ7
                s_nxt.sdone   = 1'b1;
            end else begin
                s_nxt.scnt = s_r.scnt + 2'h1;
            end
        end
        // byte lane enables
        lane_oe_n[BYTE_W-1:0] = s_r.cur.lo_en ? '0 : '1;   // see RQ10
        if (WIDE) begin
            lane_oe_n[DATA_W-1:BYTE_W] =
                s_r.cur.hi_en ? '0 : '1;                   // see RQ8
        end else begin
            lane_oe_n[DATA_W-1:BYTE_W] = '0;               // address-only
        end
        // bus cycle sequencing, each state lasts two phases
        if (s_r.ph == CLK_PH_HI) begin
            case (s_r.st)
                MAB_IDLE: begin
                    if (req_valid && s_r.sdone && !idle_pins) begin
                        s_nxt.cur = req;
                        s_nxt.st  = MAB_T1;                // see RQ15
                        s_nxt.sup = ~s_r.address_disable_strap_lo
                            & disable_address_bit
                            & req.sel_mem;                 // see RQ9 RQ13
                    end
                end
                MAB_T1: s_nxt.st = MAB_T2;
                MAB_T2: s_nxt.st = MAB_T3;
                MAB_T3: begin
                    s_nxt.st = MAB_T4;
                    if (!s_r.cur.write && !s_r.cur.internal) begin
                        s_nxt.rd = mux_s_r;                // see RQ6
                        s_nxt.rv = 1'b1;
                    end else if (!s_r.cur.write) begin
                        s_nxt.rd = int_rd_data;
                        s_nxt.rv = 1'b1;
                    end
                    if (!WIDE) begin
                        s_nxt.rd[DATA_W-1:BYTE_W] = '0;    // see RQ8
                    end
                end
                MAB_T4: s_nxt.st = MAB_IDLE;
                default: s_nxt.st = MAB_IDLE;
            endcase
        end
        // nonmux address: updated half a period ahead of mux lines
        if (idle_pins) begin
            s_nxt.na_oe_n = 1'b1;                          // see RQ3
        end else if (s_r.ph == CLK_PH_HI && s_r.st == MAB_IDLE
                     && req_valid && s_r.sdone) begin
            s_nxt.na      = req.addr;                      // see RQ2
            s_nxt.na_oe_n = 1'b0;
        end
        // mux line drive, applied on the phase-low half of each state
        addr_lo = s_r.cur.addr[DATA_W-1:0];
        if (idle_pins || s_r.st == MAB_IDLE) begin
            s_nxt.moe_n = '1;                              // see RQ11
        end else if (s_r.ph == CLK_PH_LO) begin
            case (s_r.st)
                MAB_T1: begin
                    s_nxt.mo    = addr_lo;                 // see RQ4
                    s_nxt.moe_n = s_r.sup ? '1 : '0;       // see RQ13
                    if (!WIDE) begin
                        s_nxt.moe_n[DATA_W-1:BYTE_W] = '0;
                    end
                end
                MAB_T2, MAB_T3, MAB_T4: begin
                    s_nxt.moe_n = '1;
                    if (s_r.cur.write) begin
                        s_nxt.mo    = s_r.cur.wdata;       // see RQ5
                        s_nxt.moe_n = lane_oe_n;           // see RQ10
                    end else if (s_r.cur.internal
                                 && show_read_en
                                 && s_r.st != MAB_T2) begin
                        s_nxt.mo    = int_rd_data;         // see RQ7
                        s_nxt.moe_n = lane_oe_n;
                    end
                    if (!WIDE) begin
                        s_nxt.mo[DATA_W-1:BYTE_W] =
                            addr_lo[DATA_W-1:BYTE_W];      // see RQ8
                        s_nxt.moe_n[DATA_W-1:BYTE_W] = '0;
                    end
                end
                default: s_nxt.moe_n = '1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r         <= '0;
            s_r.st      <= MAB_IDLE;
            s_r.na_oe_n <= 1'b1;   // floats in reset, see RQ3
            s_r.moe_n   <= '1;     // floats in reset, see RQ11
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign show_read_en       = s_r.sren_lo | show_read_bit;  // see RQ7
    assign pins_locked_normal = s_r.address_disable_strap_lo;                  // see RQ1
    assign addr_suppress_en   = s_r.sdone & ~s_r.address_disable_strap_lo;     // see RQ9
    assign reset_config       = s_r.cfg;
    assign first_clock_output = s_r.ph;
    assign nonmux_address_outputs = s_r.na;
    assign nonmux_oe_n        = s_r.na_oe_n;
    assign mux_o              = s_r.mo;
    assign mux_oe_n           = s_r.moe_n;
    assign req_ready = s_r.st == MAB_IDLE && s_r.ph == CLK_PH_HI
                       && s_r.sdone && !idle_pins;
    assign rd_valid           = s_r.rv;
    assign rd_data            = s_r.rd;
endmodule
`default_nettype wire

// [bench/mab_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module mab_mem (
    // device pins and stimulus values
    input  wire logic                       rst_n,
    input  wire logic [mab_pkg::DATA_W-1:0] mux_o,
    input  wire logic [mab_pkg::DATA_W-1:0] mux_oe_n,
    input  wire logic [mab_pkg::DATA_W-1:0] cfg,
    input  wire logic [mab_pkg::DATA_W-1:0] rdata,
    output logic      [mab_pkg::DATA_W-1:0] mux_i
);
    import mab_pkg::*;
    // straps during reset, read data where the device floats
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            mux_i[i] = !mux_oe_n[i] ? mux_o[i] :
                       (!rst_n ? cfg[i] : rdata[i]);
        end
    end
endmodule
`default_nettype wire

// [bench/mab_bus_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module mab_bus_properties (
    // watched ports
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       req_valid,
    input wire mab_pkg::mab_req_t          req,
    input wire logic                       req_ready,
    input wire logic                       rd_valid,
    input wire logic [mab_pkg::DATA_W-1:0] int_rd_data,
    input wire logic                       hold,
    input wire logic                       disable_address_bit,
    input wire logic [mab_pkg::ADDR_W-1:0] nonmux_address_outputs,
    input wire logic                       nonmux_oe_n,
    input wire logic [mab_pkg::DATA_W-1:0] mux_o,
    input wire logic [mab_pkg::DATA_W-1:0] mux_oe_n,
    input wire logic                       pins_locked_normal,
    input wire logic                       addr_suppress_en,
    input wire logic                       show_read_en
);
    import mab_pkg::*;
    logic tk;
    logic sup;
    // ------------------------------------------------------------
    // request taken, address phase suppressed
    // ------------------------------------------------------------
    assign tk  = req_valid && req_ready;
    assign sup = addr_suppress_en && disable_address_bit && req.sel_mem;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_lead;
        tk |=> nonmux_address_outputs == $past(req.addr) && !nonmux_oe_n;
    endproperty
    a_lead: assert property (p_lead) else $error("early address");
    property p_alow;
        tk && !sup |-> ##2 mux_o[7:0] == $past(req.addr[7:0], 2)
            && mux_oe_n[7:0] == 8'h00;
    endproperty
    a_alow: assert property (p_alow) else $error("low address");
    property p_sup;
        tk && sup |-> ##2 mux_oe_n == 16'hffff;
    endproperty
    a_sup: assert property (p_sup) else $error("suppress");
    property p_wr;
        tk && req.write && req.lo_en |-> ##4 (mux_o[7:0] ==
            $past(req.wdata[7:0], 4) && !mux_oe_n[0])
            ##1 ($stable(mux_o[7:0]) && !mux_oe_n[0]) [*5];
    endproperty
    a_wr: assert property (p_wr) else $error("write data");
    property p_lane;
        tk && !req.lo_en && !req.internal |-> ##4 (&mux_oe_n[7:0]) [*6];
    endproperty
    a_lane: assert property (p_lane) else $error("lane float");
    property p_rd;
        tk && !req.write |-> ##7 rd_valid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer");
    property p_gap;
        tk |=> !req_ready [*7];
    endproperty
    a_gap: assert property (p_gap) else $error("cycle length");
    property p_show;
        tk && req.internal && show_read_en |-> ##6
            (mux_o == int_rd_data && mux_oe_n == 16'h0000) [*4];
    endproperty
    a_show: assert property (p_show) else $error("show read");
    property p_hold;
        hold [*4] |-> nonmux_oe_n && mux_oe_n == 16'hffff;
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_cfg;
        req_ready |=> $stable(pins_locked_normal) && $stable(addr_suppress_en);
    endproperty
    a_cfg: assert property (p_cfg) else $error("mode moved");
endmodule
`default_nettype wire

// [bench/mab_bus_test.sv]
`timescale 1ns/1ps
`default_nettype none
module mab_bus_test;
    import mab_pkg::*;
    logic clk = 0, rst_n = 0, req_valid = 0, hold = 0, srb = 0, dab = 0;
    logic srs = 1, ads = 1, req_ready, rd_valid, fco, nm_oe_n, plk, ase, sre;
    mab_req_t req = '0;
    logic [15:0] ird = 0, cfg = 0, rdata = 0, mi, mo, moe_n, rd_data, rcfg;
    logic [19:0] nma;
    logic [15:0] expq[$];
    int failures = 0, compares = 0;
    integer seed = 32'h2154;
    always #2 clk = ~clk;
    mab_bus u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rd_valid(rd_valid),
        .rd_data(rd_data), .int_rd_data(ird), .hold(hold),
        .show_read_bit(srb), .disable_address_bit(dab),
        .show_read_strap(srs), .address_disable_strap(ads),
        .first_clock_output(fco), .nonmux_address_outputs(nma),
        .nonmux_oe_n(nm_oe_n), .mux_o(mo), .mux_oe_n(moe_n), .mux_i(mi),
        .reset_config(rcfg), .pins_locked_normal(plk),
        .addr_suppress_en(ase), .show_read_en(sre));
    mab_mem u_mem (.rst_n(rst_n), .mux_o(mo), .mux_oe_n(moe_n), .cfg(cfg),
        .rdata(rdata), .mux_i(mi));
    task cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task results;
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // reset with straps, then check captured configuration
    task rst(input logic a, input logic s);
        cfg <= 16'($random(seed));
        ads <= a;
        srs <= s;
        rst_n <= 0;
        repeat (10) @(posedge clk);
        rst_n <= 1;
        repeat (4) @(posedge clk);
        cmp(rcfg, cfg);
        cmp({15'h0, plk}, {15'h0, !a});
        cmp({15'h0, ase}, {15'h0, a});
        cmp({15'h0, sre}, {15'h0, !s});
        cmp({15'h0, fco}, 16'h1);
        // strap pins turn to other uses; the mode must not follow them
        ads <= !a;
        srs <= !s;
    endtask
    // one bus cycle, noting the expected read result
    task op(input logic w, input logic lo, input logic sel, input logic inr);
        int n;
        n = 0;
        @(posedge clk);
        rdata <= 16'($random(seed));
        req_valid <= 1;
        req <= '{w, lo, 1'b1, sel, inr, ADDR_W'($random(seed)),
                 DATA_W'($random(seed))};
        @(negedge clk);
        if (!w) expq.push_back(inr ? ird : rdata);
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40) failures++;
        @(posedge clk);
        req_valid <= 0;
        // let the cycle finish before read data or controls move
        repeat (8) @(posedge clk);
    endtask
    // result watcher
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0) failures++;
            else cmp(rd_data, expq.pop_front());
        end
    end
    initial begin
        ird = 16'($random(seed));
        rst(1'b1, 1'b1);
        repeat (4) begin
            op(1, 1, 0, 0);
            op(0, 1, 0, 0);
        end
        op(1, 0, 0, 0);
        dab <= 1;
        op(1, 1, 1, 0);
        op(0, 1, 1, 0);
        srb <= 1;
        op(0, 1, 0, 1);
        srb <= 0;
        hold <= 1;
        repeat (6) @(posedge clk);
        hold <= 0;
        rst(1'b0, 1'b0);
        op(0, 1, 1, 1);
        op(1, 1, 1, 0);
        repeat (10) @(posedge clk);
        cmp(16'(expq.size()), 16'h0);
        results;
    end
    initial begin
        #20000;
        failures++;
        results;
    end
endmodule
bind mab_bus mab_bus_properties u_prop (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rd_valid(rd_valid), .int_rd_data(int_rd_data), .hold(hold),
    .disable_address_bit(disable_address_bit),
    .nonmux_address_outputs(nonmux_address_outputs),
    .nonmux_oe_n(nonmux_oe_n), .mux_o(mux_o), .mux_oe_n(mux_oe_n),
    .pins_locked_normal(pins_locked_normal),
    .addr_suppress_en(addr_suppress_en), .show_read_en(show_read_en));
`default_nettype wire
